// ### tb.sv
// Self-checking bench for one synthesizer voice.
// Assumes voice_pkg and voice_gen compiled first; one 20 MHz clock.
module tb
	import voice_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;

	localparam int CPM = 20;
	logic clock;
	logic reset;
	logic wr_en;
	logic rd_en;
	logic [4:0] addr;
	logic [7:0] wr_data;
	logic [15:0] tone_step;
	logic [7:0] rd_data;
	logic [19:0] voice_out;
	logic [7:0] env_level;
	int error_cnt = 0;
	int num_checks = 0;

	voice_gen #(.cycles_per_ms(CPM)) dut_u (
		.clock(clock),
		.reset(reset),
		.wr_en(wr_en),
		.rd_en(rd_en),
		.addr(addr),
		.wr_data(wr_data),
		.tone_step(tone_step),
		.rd_data(rd_data),
		.voice_out(voice_out),
		.env_level(env_level)
	);

	always #25 clock = ~clock;

	// ==========================================================
	// Helpers
	function automatic int step_cyc(input int ms);
		int c;
		c = ms * CPM / 255;
		return (c < 1) ? 1 : c;
	endfunction : step_cyc

	// Sawtooth at full envelope: next sample is one ramp step higher
	function automatic logic [19:0] saw_next(input logic [19:0] prev);
		logic [11:0] q;
		q = 12'(prev / 20'h000ff) + 12'h001;
		return 20'(q) * 20'h000ff;
	endfunction : saw_next

	task automatic chk(input logic [19:0] got, input logic [19:0] exp);
		num_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic chk_near(input int got, input int exp, input int tol);
		num_checks++;
		if (got > exp + tol || got < exp - tol) begin
			error_cnt++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk_near

	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		@(posedge clock);
		#2;
		wr_en = 1'b1;
		addr = a;
		wr_data = d;
		@(posedge clock);
		#2;
		wr_en = 1'b0;
	endtask : wr

	task automatic rd_chk(input logic [4:0] a, input logic [7:0] exp);
		@(posedge clock);
		#2;
		rd_en = 1'b1;
		addr = a;
		@(posedge clock);
		#2;
		rd_en = 1'b0;
		chk({12'h000, rd_data}, {12'h000, exp});
	endtask : rd_chk

	task automatic wait_env(input logic [7:0] lvl, input int lim, output int n);
		n = 0;
		while (env_level !== lvl && n < lim) begin
			@(posedge clock);
			#1;
			n++;
		end
		chk({12'h000, env_level}, {12'h000, lvl});
	endtask : wait_env

	task automatic tally_and_finish;
		$display("checks=%0d errors=%0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : tally_and_finish

	// ==========================================================
	// Watchdog
	initial begin
		repeat (40000) @(posedge clock);
		error_cnt++;
		tally_and_finish();
	end

	// ==========================================================
	// Main sequence
	initial begin
		int n;
		int hi;
		logic [7:0] v;
		logic [11:0] pw;
		logic [19:0] last_out;
		logic [4:0] regs [4];
		logic [7:0] codes [8];
		regs = '{PW_LO_ADDR, PW_HI_ADDR, AD_ADDR, SR_ADDR};
		codes = '{8'h11, 8'h10, 8'h21, 8'h20, 8'h41, 8'h40, 8'h81, 8'h80};
		clock = 1'b0;
		reset = 1'b1;
		wr_en = 1'b0;
		rd_en = 1'b0;
		addr = 5'h00;
		wr_data = 8'h00;
		tone_step = 16'h1000;
		void'($urandom(32'h21c8));
		repeat (3) @(posedge clock);
		#2;
		reset = 1'b0;
		// Reset values and random readback
		for (int i = 0; i < 4; i++) begin
			rd_chk(regs[i], REG_RESET);
			v = 8'($urandom);
			wr(regs[i], v);
			rd_chk(regs[i], v);
		end
		wr(5'h07, 8'($urandom));
		rd_chk(5'h07, UNMAPPED_READ);
		rd_chk(5'h1f, UNMAPPED_READ);
		// Every start and stop code
		wr(AD_ADDR, 8'h00);
		wr(SR_ADDR, 8'hf0);
		for (int i = 0; i < 8; i++) begin
			wr(CTRL_ADDR, codes[i]);
			rd_chk(CTRL_ADDR, codes[i]);
			wait_env(codes[i][0] ? ENV_PEAK : 8'h00, 300, n);
			if (codes[i] == 8'h21) begin
				@(posedge clock);
				#1;
				last_out = voice_out;
				@(posedge clock);
				#1;
				chk(voice_out, saw_next(last_out));
			end
		end
		// Attack and decay timing, sustain hold, release
		wr(AD_ADDR, 8'h88);
		wr(SR_ADDR, 8'he0);
		wr(CTRL_ADDR, 8'h21);
		wait_env(ENV_PEAK, 3000, n);
		chk_near(n, 255 * step_cyc(ATTACK_MS[8]), 4);
		wait_env(8'hee, 1000, n);
		// One attack step is spent at peak before the decay begins
		chk_near(n, 17 * step_cyc(3 * ATTACK_MS[8]) + step_cyc(ATTACK_MS[8]), 4);
		repeat (50) @(posedge clock);
		chk({12'h000, env_level}, 20'h000ee);
		wr(CTRL_ADDR, 8'h20);
		wait_env(8'h00, 300, n);
		// Pulse duty at peak envelope
		wr(AD_ADDR, 8'h00);
		wr(SR_ADDR, 8'hf0);
		for (int k = 0; k < 2; k++) begin
			pw = (k == 0) ? 12'h800 : 12'($urandom_range(4000, 16));
			wr(PW_LO_ADDR, pw[7:0]);
			wr(PW_HI_ADDR, {4'($urandom), pw[11:8]});
			wr(CTRL_ADDR, 8'h41);
			wait_env(ENV_PEAK, 300, n);
			hi = 0;
			repeat (4096) begin
				@(posedge clock);
				#1;
				if (voice_out !== 20'h00000) begin
					hi++;
					chk(voice_out, 20'hfef01);
				end
			end
			chk_near(hi, int'(pw), 2);
			wr(CTRL_ADDR, 8'h40);
			wait_env(8'h00, 300, n);
			@(posedge clock);
			#1;
			chk(voice_out, 20'h00000);
		end
		tally_and_finish();
	end

endmodule : tb

// ### voice_gen.sv
// One voice: waveform select, gate, pulse width and envelope generator.
// Assumes register writes and tone_step come from logic on the same clock.
module voice_gen
	import voice_pkg::*;
#(
	parameter int cycles_per_ms = CYCLES_PER_MS
) (
	input wire logic clock,
	input wire logic reset,
	input wire logic wr_en,
	input wire logic rd_en,
	input wire logic [4:0] addr,
	input wire logic [7:0] wr_data,
	input wire logic [15:0] tone_step,
	output logic [7:0] rd_data,
	output logic [19:0] voice_out,
	output logic [7:0] env_level
);

	// ==========================================================
	// Registers
	logic [7:0] pw_lo_ff, nxt_pw_lo;
	logic [7:0] pw_hi_ff, nxt_pw_hi;
	voice_ctrl_t ctrl_ff, nxt_ctrl;
	nibbles_t ad_ff, nxt_ad;
	nibbles_t sr_ff, nxt_sr;
	logic [7:0] rd_data_ff, nxt_rd_data;
	logic [11:0] pulse_width_value;

	always_comb begin
		nxt_pw_lo = pw_lo_ff;
		nxt_pw_hi = pw_hi_ff;
		nxt_ctrl = ctrl_ff;
		nxt_ad = ad_ff;
		nxt_sr = sr_ff;
		if (wr_en) begin
			if (addr == PW_LO_ADDR) begin
				nxt_pw_lo = wr_data;
			end else if (addr == PW_HI_ADDR) begin
				nxt_pw_hi = wr_data;
			end else if (addr == CTRL_ADDR) begin
				nxt_ctrl = voice_ctrl_t'(wr_data);
			end else if (addr == AD_ADDR) begin
				nxt_ad = nibbles_t'(wr_data);
			end else if (addr == SR_ADDR) begin
				nxt_sr = nibbles_t'(wr_data);
			end
		end
		nxt_rd_data = rd_data_ff;
		if (rd_en) begin
			if (addr == PW_LO_ADDR) begin
				nxt_rd_data = pw_lo_ff;
			end else if (addr == PW_HI_ADDR) begin
				nxt_rd_data = pw_hi_ff;
			end else if (addr == CTRL_ADDR) begin
				nxt_rd_data = ctrl_ff;
			end else if (addr == AD_ADDR) begin
				nxt_rd_data = ad_ff;
			end else if (addr == SR_ADDR) begin
				nxt_rd_data = sr_ff;
			end else begin
				nxt_rd_data = UNMAPPED_READ;
			end
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			pw_lo_ff <= REG_RESET;
			pw_hi_ff <= REG_RESET;
			ctrl_ff <= voice_ctrl_t'(REG_RESET);
			ad_ff <= nibbles_t'(REG_RESET);
			sr_ff <= nibbles_t'(REG_RESET);
			rd_data_ff <= REG_RESET;
		end else begin
			pw_lo_ff <= nxt_pw_lo;
			pw_hi_ff <= nxt_pw_hi;
			ctrl_ff <= nxt_ctrl;
			ad_ff <= nxt_ad;
			sr_ff <= nxt_sr;
			rd_data_ff <= nxt_rd_data;
		end
	end

	assign rd_data = rd_data_ff;
	assign pulse_width_value = {pw_hi_ff[3:0], pw_lo_ff};

	// ==========================================================
	// Oscillator and waveforms
	logic [23:0] phase_ff, nxt_phase;
	logic [22:0] lfsr_ff, nxt_lfsr;
	logic [11:0] acc12, tri_w, saw_w, pulse_w, noise_w, wave;

	assign acc12 = phase_ff[23:12];
	assign saw_w = acc12;
	assign tri_w = {(phase_ff[23] ? ~phase_ff[22:12] : phase_ff[22:12]), 1'b0};
	// High while phase below width: duty = width / 4096
	assign pulse_w = (acc12 < pulse_width_value) ? WAVE_FULL : 12'h000;
	assign noise_w = lfsr_ff[22:11];

	always_comb begin
		wave = WAVE_FULL;
		if (ctrl_ff.triangle) begin
			wave = wave & tri_w;
		end
		if (ctrl_ff.saw) begin
			wave = wave & saw_w;
		end
		if (ctrl_ff.pulse) begin
			wave = wave & pulse_w;
		end
		if (ctrl_ff.noise) begin
			wave = wave & noise_w;
		end
		if (!(ctrl_ff.triangle || ctrl_ff.saw || ctrl_ff.pulse || ctrl_ff.noise)) begin
			wave = 12'h000;
		end
		nxt_phase = phase_ff + {8'h00, tone_step};
		nxt_lfsr = lfsr_ff;
		// Noise advances on each rising edge of a phase bit
		if (nxt_phase[NOISE_CLK_BIT] && !phase_ff[NOISE_CLK_BIT]) begin
			nxt_lfsr = {lfsr_ff[21:0], lfsr_ff[22] ^ lfsr_ff[17]};
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			phase_ff <= 24'h000000;
			lfsr_ff <= LFSR_SEED;
		end else begin
			phase_ff <= nxt_phase;
			lfsr_ff <= nxt_lfsr;
		end
	end

	// ==========================================================
	// Envelope generator
	env_state_t state_ff, nxt_state;
	logic [7:0] env_ff, nxt_env;
	logic [31:0] cnt_ff, nxt_cnt;
	logic gate_q_ff;
	logic [7:0] sus_level;
	logic [31:0] period;
	logic tick;

	function automatic logic [31:0] step_cycles(input logic [3:0] idx, input int mult);
		int unsigned total;
		total = ATTACK_MS[idx] * mult * cycles_per_ms;
		step_cycles = 32'(total / ENV_STEPS);
		if (step_cycles == 32'h0) begin
			step_cycles = 32'h1;
		end
	endfunction : step_cycles

	assign sus_level = {sr_ff.hi, sr_ff.hi};

	always_comb begin
		if (state_ff == ST_ATTACK) begin
			period = step_cycles(ad_ff.hi, 1);
		end else if (state_ff == ST_DECAY) begin
			period = step_cycles(ad_ff.lo, DECAY_FACTOR);
		end else begin
			period = step_cycles(sr_ff.lo, DECAY_FACTOR);
		end
	end

	assign tick = (cnt_ff >= period - 32'h1);

	always_comb begin
		nxt_state = state_ff;
		nxt_env = env_ff;
		nxt_cnt = tick ? 32'h0 : cnt_ff + 32'h1;
		case (state_ff)
			ST_ATTACK: begin
				if (tick) begin
					if (env_ff == ENV_PEAK) begin
						nxt_state = ST_DECAY;
					end else begin
						nxt_env = env_ff + 8'h01;
					end
				end
			end
			ST_DECAY: begin
				if (env_ff <= sus_level) begin
					nxt_state = ST_SUSTAIN;
				end else if (tick) begin
					nxt_env = env_ff - 8'h01;
				end
			end
			ST_SUSTAIN: begin
				nxt_cnt = 32'h0;
			end
			ST_RELEASE: begin
				if (env_ff == 8'h00) begin
					nxt_state = ST_IDLE;
				end else if (tick) begin
					nxt_env = env_ff - 8'h01;
				end
			end
			default: begin
				nxt_cnt = 32'h0;
			end
		endcase
		// Gate edges override the running phase
		if (ctrl_ff.gate && !gate_q_ff) begin
			nxt_state = ST_ATTACK;
			nxt_cnt = 32'h0;
		end else if (!ctrl_ff.gate && gate_q_ff) begin
			nxt_state = ST_RELEASE;
			nxt_cnt = 32'h0;
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			state_ff <= ST_IDLE;
			env_ff <= 8'h00;
			cnt_ff <= 32'h0;
			gate_q_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			env_ff <= nxt_env;
			cnt_ff <= nxt_cnt;
			gate_q_ff <= ctrl_ff.gate;
		end
	end

	assign env_level = env_ff;

	// ==========================================================
	// Output
	logic [19:0] out_ff, nxt_out;

	always_comb begin
		nxt_out = wave * env_ff;
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			out_ff <= 20'h00000;
		end else begin
			out_ff <= nxt_out;
		end
	end

	assign voice_out = out_ff;

	// ==========================================================
	// Checks
	tri_start_a: assert property (@(posedge clock) disable iff (reset)
		wr_en && addr == CTRL_ADDR && wr_data == 8'h11 |=> ctrl_ff.triangle && ctrl_ff.gate
		##1 state_ff == ST_ATTACK)
		else $error("triangle start not taken");

	saw_stop_a: assert property (@(posedge clock) disable iff (reset)
		wr_en && addr == CTRL_ADDR && wr_data == 8'h20 |=> ctrl_ff.saw && !ctrl_ff.gate)
		else $error("sawtooth stop not taken");

	pulse_start_a: assert property (@(posedge clock) disable iff (reset)
		wr_en && addr == CTRL_ADDR && wr_data == 8'h41 |=> ctrl_ff.pulse && ctrl_ff.gate)
		else $error("pulse start not taken");

	noise_stop_a: assert property (@(posedge clock) disable iff (reset)
		wr_en && addr == CTRL_ADDR && wr_data == 8'h80 |=> ctrl_ff.noise && !ctrl_ff.gate)
		else $error("noise stop not taken");

	pw_value_a: assert property (@(posedge clock) disable iff (reset)
		wr_en && addr == PW_HI_ADDR |=> pulse_width_value[11:8] == $past(wr_data[3:0]))
		else $error("pulse width high nibble wrong");

	square_wave_a: assert property (@(posedge clock) disable iff (reset)
		pulse_width_value == 12'h800 |-> pulse_w == (phase_ff[23] ? 12'h000 : WAVE_FULL))
		else $error("square wave duty wrong");

	release_entry_a: assert property (@(posedge clock) disable iff (reset)
		$fell(ctrl_ff.gate) |=> state_ff == ST_RELEASE)
		else $error("release not entered");

	sustain_hold_a: assert property (@(posedge clock) disable iff (reset)
		state_ff == ST_SUSTAIN && ctrl_ff.gate && gate_q_ff |=> $stable(env_ff))
		else $error("sustain level moved");

	decay_floor_a: assert property (@(posedge clock) disable iff (reset)
		state_ff == ST_DECAY ##1 state_ff == ST_SUSTAIN |-> env_ff <= sus_level)
		else $error("decay overshot sustain");

	output_mul_a: assert property (@(posedge clock) disable iff (reset)
		##1 voice_out == 20'($past(wave) * $past(env_ff)))
		else $error("voice output mismatch");

endmodule : voice_gen

// ### voice_pkg.sv
// Constants, register map and carrier types for one synthesizer voice.
// Assumes a single 20 MHz clock shared by every user of the package.
package voice_pkg;

	// ==========================================================
	// Register map (byte offsets on the register port)
	localparam logic [4:0] PW_LO_ADDR = 5'h02;
	localparam logic [4:0] PW_HI_ADDR = 5'h03;
	localparam logic [4:0] CTRL_ADDR = 5'h04;
	localparam logic [4:0] AD_ADDR = 5'h05;
	localparam logic [4:0] SR_ADDR = 5'h06;
	localparam logic [7:0] REG_RESET = 8'h00;
	localparam logic [7:0] UNMAPPED_READ = 8'h00;

	// ==========================================================
	// Timing
	localparam int CLOCK_HZ = 20_000_000;
	localparam int CYCLES_PER_MS = CLOCK_HZ / 1000;
	localparam int DECAY_FACTOR = 3;
	localparam int ENV_STEPS = 255;
	localparam logic [7:0] ENV_PEAK = 8'hff;
	localparam int unsigned ATTACK_MS [16] = '{2, 8, 16, 24, 38, 56, 68, 80,
		100, 250, 500, 800, 1000, 3000, 5000, 8000};

	// ==========================================================
	// Waveform constants
	localparam logic [11:0] WAVE_FULL = 12'hfff;
	localparam logic [22:0] LFSR_SEED = 23'h7ffff8;
	localparam int NOISE_CLK_BIT = 19;

	// ==========================================================
	// Carriers
	typedef struct packed {
		logic noise;
		logic pulse;
		logic saw;
		logic triangle;
		logic [2:0] spare;
		logic gate;
	} voice_ctrl_t;

	typedef struct packed {
		logic [3:0] hi;
		logic [3:0] lo;
	} nibbles_t;

	typedef enum logic [4:0] {
		ST_IDLE = 5'b00001,
		ST_ATTACK = 5'b00010,
		ST_DECAY = 5'b00100,
		ST_SUSTAIN = 5'b01000,
		ST_RELEASE = 5'b10000
	} env_state_t;

endpackage : voice_pkg
